// file: ewsc_wait_ctrl.sv
// Wait-state and translation-enable control for the emulator bus.
//
// Notes on behaviour
// - Fast-clock setting adds exactly one wait to every emulation access.
// - Slow clock and no slow modules gives zero-wait emulation accesses.
// - A slow 4-Mbyte module in either slot forces one wait.
// - Target accesses are lengthened by the device only by the wait period, when waits are on.
// - With waits on, target terminations are ignored for one wait period.
// - Translation enable only with foreground monitor; refusal is reported.
// - Translation is usable only after the configuration enable is applied.
// - Target disable input overrides the configured translation enable.
// - Unlocked emulation blocks ignore target acknowledges, end internally.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ewsc_params.svh"
module ewsc_wait_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [`EWSC_SLOT_COUNT-1:0] slot_slow_i,
  input wire logic cycle_start_i,
  input wire logic cycle_emul_i,
  input wire logic cycle_lock_i,
  input wire logic transfer_acknowledge_i,
  input wire logic transfer_error_acknowledge_i,
  input wire logic translation_disable_input_i,
  output logic cycle_done_o,
  output logic cycle_error_o,
  output logic translation_enable_o,
  output logic xlat_refused_o
);
  import ewsc_pkg::*;

  logic [`EWSC_CFG_WIDTH-1:0] cfg_q;
  logic [`EWSC_CFG_WIDTH-1:0] cfg_d;
  logic refused_q;
  logic refused_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  ewsc_cycle_type state_q;
  ewsc_cycle_type state_d;
  logic emul_q;
  logic emul_d;
  logic lock_q;
  logic lock_d;
  logic [1:0] waits_q;
  logic [1:0] waits_d;
  logic [1:0] waits_now;
  logic hold_done;
  logic term_in;
  logic in_cycle;
  ewsc_monitor_type mon_sel;

  // Monitor code held in the config register; 3 decodes as none.
  function automatic ewsc_monitor_type mon_of(input logic [1:0] f);
    case (f)
      2'h1: mon_of = EWSC_MON_BACKGROUND;
      2'h2: mon_of = EWSC_MON_FOREGROUND;
      default: mon_of = EWSC_MON_NONE;
    endcase
  endfunction : mon_of

  assign mon_sel = mon_of(cfg_q[`EWSC_CFG_MON_LSB+1:`EWSC_CFG_MON_LSB]);

  // A slow module in any slot or the fast-clock setting asks for a wait.
  assign waits_now = (cfg_q[`EWSC_CFG_WAIT_BIT] || (|slot_slow_i)) ?
    2'(`EWSC_WAIT_STATES) : 2'h0;

  // Config writes; a translation enable without foreground is refused.
  always_comb begin
    cfg_d = cfg_q;
    refused_d = refused_q;
    rdata_d = 8'h00;
    if (reg_wr_i && reg_addr_i == `EWSC_ADDR_CFG) begin
      cfg_d = reg_wdata_i[`EWSC_CFG_WIDTH-1:0];
      refused_d = 1'b0;
      if (reg_wdata_i[`EWSC_CFG_XLAT_BIT] &&
          mon_of(reg_wdata_i[3:2]) != EWSC_MON_FOREGROUND) begin
        cfg_d[`EWSC_CFG_XLAT_BIT] = 1'b0;
        refused_d = 1'b1;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `EWSC_ADDR_CFG) begin
        rdata_d = {4'h0, cfg_q};
      end else if (reg_addr_i == `EWSC_ADDR_STATUS) begin
        rdata_d = {4'h0, in_cycle, translation_enable_o, refused_q,
          waits_q[0]};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_q <= `EWSC_CFG_RESET;
      refused_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign xlat_refused_o = refused_q;

  // Configured enable only ever reaches the unit; the target pin wins.
  assign translation_enable_o = cfg_q[`EWSC_CFG_XLAT_BIT] &&
    !translation_disable_input_i;

  // Termination inputs that matter for this cycle.
  assign term_in = transfer_acknowledge_i || transfer_error_acknowledge_i;
  assign in_cycle = (state_q != EWSC_IDLE);

  ewsc_hold_timer u_hold (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(cycle_start_i && !in_cycle),
    .waits_i(waits_now),
    .done_o(hold_done)
  );

  // Cycle tracker; wait count is frozen at cycle start.
  always_comb begin
    state_d = state_q;
    emul_d = emul_q;
    lock_d = lock_q;
    waits_d = waits_q;
    cycle_done_o = 1'b0;
    cycle_error_o = 1'b0;
    case (state_q)
      EWSC_IDLE: begin
        if (cycle_start_i) begin
          waits_d = waits_now;
          emul_d = cycle_emul_i;
          lock_d = cycle_lock_i;
          state_d = (waits_now == 2'h0) ? EWSC_OPEN : EWSC_WAIT;
          if (waits_now == 2'h0 && cycle_emul_i && !cycle_lock_i) begin
            cycle_done_o = 1'b1;
            state_d = EWSC_IDLE;
          end
        end
      end
      EWSC_WAIT: begin
        // Terminations seen during the wait are ignored.
        if (hold_done) begin
          state_d = EWSC_OPEN;
        end
      end
      EWSC_OPEN: begin
        if (emul_q && !lock_q) begin
          cycle_done_o = 1'b1;
          state_d = EWSC_IDLE;
        end else if (term_in) begin
          // Target paces its own cycle; no extra wait added here.
          cycle_done_o = 1'b1;
          cycle_error_o = transfer_error_acknowledge_i;
          state_d = EWSC_IDLE;
        end
      end
      default: state_d = EWSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= EWSC_IDLE;
      emul_q <= 1'b0;
      lock_q <= 1'b0;
      waits_q <= 2'h0;
    end else begin
      state_q <= state_d;
      emul_q <= emul_d;
      lock_q <= lock_d;
      waits_q <= waits_d;
    end
  end

  property no_early_term_p;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == EWSC_IDLE && cycle_start_i && waits_now != 2'h0)
      |=> !cycle_done_o;
  endproperty
  hold_off_term_a: assert property (no_early_term_p)
    else $error("termination accepted inside the wait state");
  emul_one_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == EWSC_IDLE && cycle_start_i && cycle_emul_i && !cycle_lock_i
     && waits_now == 2'h1) |=> !cycle_done_o ##1 cycle_done_o)
    else $error("emulation access did not take one wait");
  emul_zero_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == EWSC_IDLE && cycle_start_i && cycle_emul_i && !cycle_lock_i
     && !cfg_q[0] && slot_slow_i == 2'b00) |-> cycle_done_o)
    else $error("zero-wait emulation access was delayed");
  slot_forces_wait_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (|slot_slow_i) |-> waits_now == 2'h1)
    else $error("slow module did not force a wait");
  target_no_stretch_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (state_q == EWSC_OPEN && !emul_q && term_in)
    |-> cycle_done_o)
    else $error("target cycle was lengthened");
  xlat_fg_only_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    translation_enable_o |-> mon_sel == EWSC_MON_FOREGROUND)
    else $error("translation enabled without foreground monitor");
  xlat_config_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cfg_q[1] |-> !translation_enable_o)
    else $error("translation enabled without configuration");
  target_disable_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    translation_disable_input_i |-> !translation_enable_o)
    else $error("target disable ignored");
  unlock_ignore_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (emul_q && !lock_q && cycle_done_o) |-> !cycle_error_o)
    else $error("unlocked emulation cycle took a target error");
  wait_stable_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_cycle && $past(in_cycle)) |-> $stable(waits_q))
    else $error("wait count changed inside a cycle");

  emul_wait_c: cover property (@(posedge clk_sys_i)
    state_q == EWSC_WAIT && emul_q);
  target_term_c: cover property (@(posedge clk_sys_i)
    state_q == EWSC_OPEN && !emul_q && term_in);
  refused_c: cover property (@(posedge clk_sys_i) refused_q);
  override_c: cover property (@(posedge clk_sys_i)
    cfg_q[1] && translation_disable_input_i);
endmodule : ewsc_wait_ctrl

// file: ewsc_params.svh
// Constants for the emulation wait-state control block.
`ifndef EWSC_PARAMS_SVH
`define EWSC_PARAMS_SVH
`define EWSC_CLK_MHZ 20
`define EWSC_FAST_CLK_MHZ 25
`define EWSC_SLOW_MEM_NS 25
`define EWSC_WAIT_STATES 1
`define EWSC_SLOT_COUNT 2
`define EWSC_CFG_WAIT_BIT 0
`define EWSC_CFG_XLAT_BIT 1
`define EWSC_CFG_MON_LSB 2
`define EWSC_CFG_WIDTH 4
`define EWSC_ADDR_CFG 4'h0
`define EWSC_ADDR_STATUS 4'h1
`define EWSC_CFG_RESET 4'h0
`endif

// file: ewsc_pkg.sv
// Types for the emulation wait-state control block.
package ewsc_pkg;
  typedef enum logic [1:0] {
    EWSC_MON_NONE,
    EWSC_MON_BACKGROUND,
    EWSC_MON_FOREGROUND
  } ewsc_monitor_type;
  typedef enum logic [1:0] {
    EWSC_IDLE,
    EWSC_WAIT,
    EWSC_OPEN
  } ewsc_cycle_type;
endpackage : ewsc_pkg

// file: ewsc_hold_timer.sv
// One-shot wait counter that holds off cycle completion.
`timescale 1ns/1ps
`include "ewsc_params.svh"
module ewsc_hold_timer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [1:0] waits_i,
  output logic done_o
);
  logic [1:0] count_q;
  logic [1:0] count_d;

  // Loads on start and counts down one per clock to zero.
  always_comb begin
    count_d = count_q;
    if (start_i) begin
      count_d = waits_i;
    end else if (count_q != 2'h0) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end

  // Done marks the last waiting cycle, so the caller leaves its wait at
  // this edge; a zero-wait start completes at once.
  assign done_o = start_i ? (waits_i == 2'h0) : (count_q <= 2'h1);
endmodule : ewsc_hold_timer

// file: ewsc_tgt_model.sv
// Behavioural target bus that ends each bus cycle.
`timescale 1ns/1ps
module ewsc_tgt_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic done_i,
  input wire logic [1:0] dly_i,
  input wire logic err_i,
  output logic ack_o,
  output logic term_err_o
);
  logic act_q;
  logic [1:0] cnt_q;
  // Count cycles since the start; a done ends the cycle.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || done_i) begin
      act_q <= 1'h0;
      cnt_q <= 2'h0;
    end else if (start_i && !act_q) begin
      act_q <= 1'h1;
      cnt_q <= 2'h1;
    end else if (act_q && cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Held until done, so an early one shows if the device ignores it.
  assign ack_o = act_q && cnt_q >= dly_i && !err_i;
  assign term_err_o = act_q && cnt_q >= dly_i && err_i;
endmodule : ewsc_tgt_model

// file: tb_ewsc_wait_ctrl.sv
// Self-checking bench for the wait-state control block.
`timescale 1ns/1ps
module tb_ewsc_wait_ctrl;
  logic clk_sys_i = 0, rst_i = 1, wr = 0, rd = 0, start = 0, emul = 0;
  logic lock = 0, dis = 0, err = 0, rd_d = 0, busy = 0;
  logic e, l, w, x, dd, xc, rf, done, cerr, xen, refd, ack, fail;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rdata, exp8;
  logic [1:0] slow = 0, dly = 1, s, dl;
  logic [2:0] n = 0, ln;
  int n_fail = 0, cmp_count = 0, tick = 0, seed = 32'ha855;
  logic [7:0] rq[$], cq[$];
  ewsc_wait_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .slot_slow_i(slow), .cycle_start_i(start),
    .cycle_emul_i(emul), .cycle_lock_i(lock),
    .transfer_acknowledge_i(ack), .transfer_error_acknowledge_i(fail),
    .translation_disable_input_i(dis), .cycle_done_o(done),
    .cycle_error_o(cerr), .translation_enable_o(xen), .xlat_refused_o(refd));
  ewsc_tgt_model tgt (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start),
    .done_i(done), .dly_i(dly), .err_i(err), .ack_o(ack), .term_err_o(fail));
  // A 50 ns clock.
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d fails=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk_sys_i);
    wr <= 1'h0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] v);
    rq.push_back(v);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys_i);
    rd <= 1'h0;
  endtask : rreg
  // One bus cycle; drop clears the slow slots while it is open.
  task automatic cyc(input logic [7:0] v, input logic drop);
    cq.push_back(v);
    @(posedge clk_sys_i);
    start <= 1'h1;
    emul <= e;
    lock <= l;
    @(posedge clk_sys_i);
    start <= 1'h0;
    if (drop) slow <= 2'h0;
    repeat (8) begin
      @(negedge clk_sys_i);
      if (!busy && !done) break;
    end
  endtask : cyc
  // Measure cycle length and watch for a hang.
  always @(posedge clk_sys_i) begin
    rd_d <= rd;
    n <= (start && !busy) ? 3'h1 : n + 3'h1;
    if (done) busy <= 1'h0;
    else if (start && !busy) busy <= 1'h1;
    tick++;
    if (tick == 3000) begin
      n_fail++;
      finish_test;
    end
  end
  // Results are settled mid-cycle; each takes the oldest note.
  always @(negedge clk_sys_i) begin
    if (rd_d) chk(rdata, rq.size() ? rq.pop_front() : 8'hxx);
    if (done) begin
      exp8 = cq.size() ? cq.pop_front() : 8'hxx;
      chk({4'h0, cerr, busy ? n : 3'h0}, exp8);
    end
  end
  // Main sequence: registers, cycle lengths, then translation enable.
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    rreg(4'h1, 8'h00);
    wreg(4'h7, 8'hff);
    rreg(4'h7, 8'h00);
    rreg(4'h0, 8'h00);
    for (int i = 0; i < 24; i++) begin
      e = i[0];
      l = i[1];
      // Early rounds keep the slots fast so zero-wait accesses must occur.
      s = (i < 8) ? 2'h0 : 2'($random(seed));
      dl = 2'h1 + 2'({$random(seed)} % 3);
      x = $random(seed);
      w = i[2] | (|s);
      @(posedge clk_sys_i);
      slow <= s;
      dly <= dl;
      err <= x;
      wreg(4'h0, {7'h00, i[2]});
      ln = {1'h0, dl};
      if (ln < 3'h1 + w) ln = 3'h1 + w;
      if (e && !l) ln = w ? 3'h2 : 3'h0;
      cyc({4'h0, x & ~(e & ~l), ln}, 1'h0);
      rreg(4'h1, {7'h00, w});
    end
    @(posedge clk_sys_i);
    slow <= 2'h1;
    wreg(4'h0, 8'h00);
    e = 1'h1;
    l = 1'h0;
    cyc(8'h02, 1'h1);
    for (int j = 0; j < 8; j++) begin
      dd = $random(seed);
      @(posedge clk_sys_i);
      dis <= dd;
      wreg(4'h0, {4'h0, j[2:1], j[0], 1'h0});
      @(negedge clk_sys_i);
      xc = j[0] && j[2:1] == 2'h2;
      rf = j[0] && !xc;
      chk({6'h00, xen, refd}, {6'h00, xc && !dd, rf});
      rreg(4'h0, {4'h0, j[2:1], xc, 1'h0});
      rreg(4'h1, {5'h00, xc && !dd, rf, 1'h1});
    end
    repeat (2) @(posedge clk_sys_i);
    if (cq.size() || rq.size()) n_fail++;
    finish_test;
  end
endmodule : tb_ewsc_wait_ctrl
